// ---- hw/period_match_timer8_regs.vh ----
`ifndef PERIOD_MATCH_TIMER8_REGS_VH
`define PERIOD_MATCH_TIMER8_REGS_VH

// Register byte addresses (word aligned)
`define TIMER_COUNT_OFF 8'h00
`define PERIOD_VALUE_OFF 8'h04
`define TIMER_CONTROL_OFF 8'h08
`define IRQ_STATUS_OFF 8'h0C
`define IRQ_MASK_OFF 8'h10

// Reset values
`define TIMER_COUNT_RST 8'h00
`define PERIOD_VALUE_RST 8'hFF
`define TIMER_CONTROL_RST 7'h00
`define IRQ_STATUS_RST 1'b0
`define IRQ_MASK_RST 1'b0

// Control field positions
`define CTL_PRESCALE_LO 0
`define CTL_PRESCALE_HI 1
`define CTL_RUN_BIT 2
`define CTL_POSTSCALE_LO 3
`define CTL_POSTSCALE_HI 6

// Status and mask bit position
`define IRQ_MATCH_BIT 0

// Prescale select encodings and terminal counts
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV4 2'h1
`define PRESCALE_TC1 4'h0
`define PRESCALE_TC4 4'h3
`define PRESCALE_TC16 4'hF

// Instruction clock is one quarter of the system oscillator
`define INSTR_CLK_DIV 2'h3

`endif

// ---- hw/prescale_divider.v ----
`timescale 1ns/1ps
`include "period_match_timer8_regs.vh"

// Divides the instruction-rate tick by 1, 4 or 16
module prescale_divider (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire tick_in,
    input wire [1:0] prescale_select,
    output wire tick_out
);
    reg [3:0] count_q;
    reg [3:0] limit;

    // Upper select bit set means divide by sixteen whatever the low bit
    always @* begin
        if (prescale_select[1]) begin
            limit = `PRESCALE_TC16;
        end else if (prescale_select == `PRESCALE_DIV4) begin
            limit = `PRESCALE_TC4;
        end else begin
            limit = `PRESCALE_TC1;
        end
    end

    assign tick_out = tick_in && (count_q >= limit);

    // Counter is cleared by count and control writes so the next period starts clean
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 4'h0;
        end else if (clear) begin
            count_q <= 4'h0;
        end else if (tick_out) begin
            count_q <= 4'h0;
        end else if (tick_in) begin
            count_q <= count_q + 4'h1;
        end
    end
endmodule // prescale_divider

// ---- hw/postscale_divider.v ----
`timescale 1ns/1ps
`include "period_match_timer8_regs.vh"

// Counts match events and pulses once per selected ratio
module postscale_divider (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire match_in,
    input wire [3:0] postscale_select,
    output wire event_out
);
    reg [3:0] count_q;

    // Ratio is field plus one, so the terminal count equals the field
    assign event_out = match_in && (count_q == postscale_select);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 4'h0;
        end else if (clear) begin
            count_q <= 4'h0;
        end else if (event_out) begin
            count_q <= 4'h0;
        end else if (match_in) begin
            count_q <= count_q + 4'h1;
        end
    end
endmodule // postscale_divider

// ---- hw/period_match_timer8.v ----
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "period_match_timer8_regs.vh"

module period_match_timer8 (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq
);
    reg [7:0] timer_count_q;
    reg [7:0] timer_count_d;
    reg [7:0] period_value_q;
    reg [7:0] period_value_d;
    reg [6:0] timer_control_q;
    reg [6:0] timer_control_d;
    reg match_irq_flag_q;
    reg match_irq_flag_d;
    reg irq_mask_q;
    reg irq_mask_d;
    reg [1:0] instr_div_q;
    reg [1:0] instr_div_d;
    reg wr_pend_q;
    reg wr_pend_d;
    reg [7:0] wr_addr_q;
    reg [7:0] wr_addr_d;
    reg [4:0] wr_sel;
    reg [31:0] rdata_d;
    reg irq_d;

    wire run;
    wire [1:0] prescale_select;
    wire [3:0] postscale_select;
    wire instr_tick;
    wire pre_tick;
    wire match;
    wire count_tick;
    wire match_event;
    wire post_event;
    wire addr_phase;
    wire rd_phase;
    wire wr_count;
    wire wr_period;
    wire wr_control;
    wire wr_status;
    wire wr_mask;
    wire flag_clear;
    wire scaler_clear;

    // Write strobe positions in the one-hot register select
    localparam SEL_COUNT = 0;
    localparam SEL_PERIOD = 1;
    localparam SEL_CONTROL = 2;
    localparam SEL_STATUS = 3;
    localparam SEL_MASK = 4;

    // Control fields as the counter and scalers see them
    assign run = timer_control_q[`CTL_RUN_BIT];
    assign prescale_select = timer_control_q[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
    assign postscale_select = timer_control_q[`CTL_POSTSCALE_HI:`CTL_POSTSCALE_LO];

    // Address phase accepted; the slave never inserts wait states
    assign addr_phase = hsel && hready && htrans[1];
    assign rd_phase = addr_phase && !hwrite;

    // Write address held over into the data phase, when hwdata stands
    always @* begin
        wr_pend_d = addr_phase && hwrite;
        wr_addr_d = wr_addr_q;
        if (addr_phase) begin
            wr_addr_d = haddr[7:0];
        end
    end

    // Data-phase write tracking
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // One strobe per register; unmapped writes fall through unseen
    always @* begin
        wr_sel = 5'h00;
        if (wr_pend_q) begin
            case (wr_addr_q)
                `TIMER_COUNT_OFF: wr_sel[SEL_COUNT] = 1'b1;
                `PERIOD_VALUE_OFF: wr_sel[SEL_PERIOD] = 1'b1;
                `TIMER_CONTROL_OFF: wr_sel[SEL_CONTROL] = 1'b1;
                `IRQ_STATUS_OFF: wr_sel[SEL_STATUS] = 1'b1;
                `IRQ_MASK_OFF: wr_sel[SEL_MASK] = 1'b1;
                default: wr_sel = 5'h00;
            endcase
        end
    end

    // Individual write strobes, valid while hwdata stands
    assign wr_count = wr_sel[SEL_COUNT];
    assign wr_period = wr_sel[SEL_PERIOD];
    assign wr_control = wr_sel[SEL_CONTROL];
    assign wr_status = wr_sel[SEL_STATUS];
    assign wr_mask = wr_sel[SEL_MASK];

    // Flag clear by writing one; scalers restart on count or control writes
    assign flag_clear = wr_status && hwdata[`IRQ_MATCH_BIT];
    assign scaler_clear = wr_count || wr_control;

    // Instruction clock phase; held at zero while halted so restarts are uniform
    always @* begin
        if (!run || scaler_clear) begin
            instr_div_d = 2'h0;
        end else begin
            instr_div_d = instr_div_q + 2'h1;
        end
    end

    // Instruction clock phase register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_div_q <= 2'h0;
        end else begin
            instr_div_q <= instr_div_d;
        end
    end

    // Quarter-rate tick models the instruction clock
    assign instr_tick = run && (instr_div_q == `INSTR_CLK_DIV);

    // Match is seen on every count value, not just at increments
    assign match = (timer_count_q == period_value_q);

    // A tick that meets a count or control write is dropped with the scalers
    assign count_tick = pre_tick && !scaler_clear;
    assign match_event = count_tick && match;

    // Prescaler between the instruction tick and the count
    prescale_divider u_prescale (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(scaler_clear),
        .tick_in(instr_tick),
        .prescale_select(prescale_select),
        .tick_out(pre_tick)
    );

    // Postscaler between the match events and the flag
    postscale_divider u_postscale (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(scaler_clear),
        .match_in(match_event),
        .postscale_select(postscale_select),
        .event_out(post_event)
    );

    // Next count; a software write beats a coincident increment
    always @* begin
        timer_count_d = timer_count_q;
        if (wr_count) begin
            timer_count_d = hwdata[7:0];
        end else if (count_tick) begin
            if (match) begin
                timer_count_d = 8'h00;
            end else begin
                timer_count_d = timer_count_q + 8'h01;
            end
        end
    end

    // Count register; control writes never reach it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_count_q <= `TIMER_COUNT_RST;
        end else begin
            timer_count_q <= timer_count_d;
        end
    end

    // Next period value
    always @* begin
        period_value_d = period_value_q;
        if (wr_period) begin
            period_value_d = hwdata[7:0];
        end
    end

    // Period register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_value_q <= `PERIOD_VALUE_RST;
        end else begin
            period_value_q <= period_value_d;
        end
    end

    // Next control; bit seven has no storage, so it always reads zero
    always @* begin
        timer_control_d = timer_control_q;
        if (wr_control) begin
            timer_control_d = hwdata[6:0];
        end
    end

    // Control register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_q <= `TIMER_CONTROL_RST;
        end else begin
            timer_control_q <= timer_control_d;
        end
    end

    // Next mask bit
    always @* begin
        irq_mask_d = irq_mask_q;
        if (wr_mask) begin
            irq_mask_d = hwdata[`IRQ_MATCH_BIT];
        end
    end

    // Mask register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_q <= `IRQ_MASK_RST;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // Sticky flag: set wins over a write-one clear in the same cycle
    always @* begin
        match_irq_flag_d = match_irq_flag_q;
        if (post_event) begin
            match_irq_flag_d = 1'b1;
        end else if (flag_clear) begin
            match_irq_flag_d = 1'b0;
        end
    end

    // Match flag register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_irq_flag_q <= `IRQ_STATUS_RST;
        end else begin
            match_irq_flag_q <= match_irq_flag_d;
        end
    end

    // Interrupt follows next flag and mask, so pin and status never disagree
    always @* begin
        irq_d = match_irq_flag_d && irq_mask_d;
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 32'h00000000;
        case (haddr[7:0])
            `TIMER_COUNT_OFF: rdata_d[7:0] = timer_count_q;
            `PERIOD_VALUE_OFF: rdata_d[7:0] = period_value_q;
            `TIMER_CONTROL_OFF: rdata_d[6:0] = timer_control_q;
            `IRQ_STATUS_OFF: rdata_d[`IRQ_MATCH_BIT] = match_irq_flag_q;
            `IRQ_MASK_OFF: rdata_d[`IRQ_MATCH_BIT] = irq_mask_q;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Registered outputs; read data sampled at the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_phase) begin
                hrdata <= rdata_d;
            end
            irq <= irq_d;
        end
    end
endmodule // period_match_timer8

// ---- dv/period_match_timer8_asserts.sv ----
`timescale 1ns/1ps
// Bus and interrupt pin checks of the timer
module period_match_timer8_asserts (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read taken in its address phase
    wire rd = hsel & hready & htrans[1] & ~hwrite;
    chk_ready_high: assert property (hreadyout) else $error("wait state");
    chk_resp_okay: assert property (!hresp) else $error("error response");
    chk_ctl_msb_zero: assert property (rd && haddr[7:0] == 8'h08 |=> hrdata[31:7] == 25'h0)
        else $error("control top bit set");
    chk_reg_width: assert property (rd && haddr[7:0] < 8'h08 |=> hrdata[31:8] == 24'h0)
        else $error("wide count");
    chk_unmapped_zero: assert property (rd && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
        else $error("unmapped data");
    chk_irq_flag: assert property (irq && rd && haddr[7:0] == 8'h0C |=> hrdata[0])
        else $error("irq without flag");
    chk_irq_mask: assert property (irq && rd && haddr[7:0] == 8'h10 |=> hrdata[0])
        else $error("irq without mask");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !irq) else $error("irq at reset");
endmodule // period_match_timer8_asserts

bind period_match_timer8 period_match_timer8_asserts chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));

// ---- dv/period_match_timer8_tb.sv ----
`timescale 1ns/1ps
// Counts a comparison and reports a mismatch
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module period_match_timer8_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, lf = 32'd97670;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire hready, hreadyout, hresp, irq;
    wire [31:0] hrdata;
    int mismatches = 0, n_compared = 0, n, k, i, pv, ps, et;
    period_match_timer8 uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    assign hready = hreadyout;
    initial begin
        forever #50 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Cycles from run to flag: quarter-rate tick, prescale, period, postscale
    function automatic int flag_time(input int pre, input int per, input int post);
        return 4 * (pre[1] ? 16 : (pre[0] ? 4 : 1)) * (per + 1) * (post + 1);
    endfunction
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait for the slave to be ready
    task wait_rdy;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin mismatches++; tally_and_finish; end
            @(posedge hclk);
        end
    endtask
    // One single word transfer, address phase then data phase
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 0; htrans <= 2'h0; hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask
    // Every register at its reset value; the last address is unmapped
    task check_reset_values;
        for (i = 0; i < 6; i++) begin
            xfer(0, 8'(i * 4), 0);
            `CHK("reset value", (i == 1) ? 32'h000000FF : 32'h0, rd)
        end
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        // Reset values, last address unmapped
        check_reset_values;
        // Random readback; control write keeps run low, top bit forced on
        for (i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            xfer(1, 8'(i * 4), (i == 2) ? ((lf | 32'h80) & ~32'h4) : lf);
            xfer(0, 8'(i * 4), 0);
            `CHK("readback", lf & ((i == 2) ? 32'h7B : 32'hFF), rd)
        end
        // A stopped count survives time and a control write
        xfer(1, 8'h00, 32'h5A);
        repeat (30) @(posedge hclk);
        xfer(1, 8'h08, 32'h7B);
        xfer(0, 8'h00, 0);
        `CHK("stopped count", 32'h5A, rd)
        // Flag set while masked, irq follows mask, clear drops it
        xfer(1, 8'h04, 0);
        xfer(1, 8'h00, 0);
        xfer(1, 8'h08, 32'h4);
        repeat (20) @(negedge hclk);
        `CHK("masked irq", 1'b0, irq)
        xfer(0, 8'h0C, 0);
        `CHK("flag", 32'h1, rd)
        xfer(1, 8'h10, 1);
        @(negedge hclk);
        `CHK("irq on", 1'b1, irq)
        xfer(0, 8'h0C, 0);
        `CHK("flag under irq", 32'h1, rd)
        xfer(0, 8'h10, 0);
        `CHK("mask under irq", 32'h1, rd)
        xfer(1, 8'h08, 0);
        xfer(1, 8'h0C, 1);
        @(negedge hclk);
        `CHK("irq off", 1'b0, irq)
        // Flag delay over every prescale code, random period, postscale 15 first then random
        for (i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            pv = lf[3:0];
            ps = (i == 0) ? 15 : lf[6:4];
            et = flag_time(i, pv, ps);
            xfer(1, 8'h04, 32'(pv));
            xfer(1, 8'h00, 0);
            xfer(1, 8'h08, 32'(ps * 8 + 4 + i));
            k = 0;
            while (irq !== 1'b1 && k < et + 20) begin
                @(negedge hclk);
                k++;
            end
            `CHK("flag delay", 1'b1, (k >= et - 2) && (k <= et + 4))
            if (irq !== 1'b1) tally_and_finish;
            xfer(1, 8'h08, 0);
            xfer(1, 8'h0C, 1);
        end
        // Reset in mid-run while the flag fires: irq drops, registers return
        xfer(1, 8'h04, 0);
        xfer(1, 8'h00, 0);
        xfer(1, 8'h08, 32'h4);
        repeat (8) @(negedge hclk);
        `CHK("irq before reset", 1'b1, irq)
        @(posedge hclk);
        hresetn <= 0;
        @(negedge hclk);
        `CHK("irq in reset", 1'b0, irq)
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        check_reset_values;
        tally_and_finish;
    end
endmodule // period_match_timer8_tb
